// file: rtl/secl_event_latch.sv
// Event-change latch of a four-port video switch, with its reserved slot.
// Assumes register requests come from the local slave on core_clk and
// that pin-level sense inputs are asynchronous to it.
//
// Behaviour
// - Offset vendor_reserved_slot read-only, value not guaranteed
// - Bit 5 flags active port change
// - Bit 4 flags active port clock-detect change
// - Bits 3:0 flag port supply-sense changes
// - Offset event_change_latch read-only, captured on interrupt rise
// - Reading 0x01 clears interrupt and latch
// - Latch keeps updating while 0x01 unread
// - All change flags reset to zero
`timescale 1ns/1ps

module secl_event_latch
	import secl_pkg::*;
#(
	parameter int NUM_PORTS = SECL_NUM_PORTS
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire secl_status_type status_in,
	input wire secl_req_type req,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic rhit,
	output logic irq
);

	// ==========================================================
	// Change detection helper
	function automatic logic [NUM_PORTS+1:0] secl_changed(
		input logic [NUM_PORTS+1:0] now_v,
		input logic [NUM_PORTS+1:0] was_v
	);
		secl_changed = now_v ^ was_v;
	endfunction

	// ==========================================================
	// Pin synchronisers for clock detect and supply sense
	logic [NUM_PORTS:0] sync1_q;
	logic [NUM_PORTS:0] sync1_d;
	logic [NUM_PORTS:0] sync2_q;
	logic [NUM_PORTS:0] sync2_d;

	always_comb
	begin
		sync1_d = sync1_q;
		sync2_d = sync2_q;
		if (clk_en)
		begin
			sync1_d = {status_in.clk_detect, status_in.port_supply_sense};
			sync2_d = sync1_q;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ==========================================================
	// Change flags and interrupt
	// Vector order matches latch bits 5:0.
	logic [NUM_PORTS+1:0] now_v;
	logic [NUM_PORTS+1:0] prev_q;
	logic [NUM_PORTS+1:0] prev_d;
	logic [NUM_PORTS+1:0] flags_q;
	logic [NUM_PORTS+1:0] flags_d;
	logic [NUM_PORTS+1:0] delta;
	logic [1:0] prev_sel_q;
	logic [1:0] prev_sel_d;
	logic [1:0] prime_q;
	logic [1:0] prime_d;
	logic prime_done;
	logic irq_q;
	logic irq_d;
	logic status_read;

	assign status_read = req.rd && (req.addr == SECL_OFS_PORT_STATUS);
	assign prime_done = (prime_q == SECL_PRIME_DONE);

	always_comb
	begin
		now_v = '0;
		now_v[SECL_BIT_CLK_DET] = sync2_q[NUM_PORTS];
		now_v[SECL_BIT_SUPPLY_HI:SECL_BIT_SUPPLY_LO] =
			sync2_q[NUM_PORTS-1:0];
		delta = '0;
		prev_d = prev_q;
		prev_sel_d = prev_sel_q;
		prime_d = prime_q;
		flags_d = flags_q;
		irq_d = irq_q;
		if (clk_en)
		begin
			// Deltas wait until the syncs hold real pin samples, so a
			// pin already high at reset never reads as a change
			if (prime_done)
			begin
				delta = secl_changed(now_v, prev_q);
				delta[SECL_BIT_PORT_SEL] =
					(status_in.port_sel != prev_sel_q);
			end
			delta[SECL_BIT_CLK_DET] =
				delta[SECL_BIT_CLK_DET] & prime_done;
			prev_d = now_v;
			prev_sel_d = status_in.port_sel;
			if (!prime_done)
				prime_d = prime_q + 2'h1;
			// New events win over a clear in the same cycle
			if (status_read)
				flags_d = delta;
			else
				flags_d = flags_q | delta;
			irq_d = |flags_d;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_q <= '0;
			prev_sel_q <= 2'h0;
			prime_q <= 2'h0;
			flags_q <= SECL_FLAGS_RST;
			irq_q <= 1'b0;
		end
		else
		begin
			prev_q <= prev_d;
			prev_sel_q <= prev_sel_d;
			prime_q <= prime_d;
			flags_q <= flags_d;
			irq_q <= irq_d;
		end
	end

	assign irq = irq_q;

	// ==========================================================
	// Event latch register
	// Captured on the interrupt's rise and refreshed on every later
	// event while it stays high; cleared with the interrupt.
	logic [7:0] latch_q;
	logic [7:0] latch_d;

	always_comb
	begin
		latch_d = latch_q;
		if (clk_en)
		begin
			if (irq_d && (!irq_q || (|delta)))
				latch_d = {2'b00, flags_d};
			else if (!irq_d)
				latch_d = SECL_EVENT_LATCH_RST;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			latch_q <= SECL_EVENT_LATCH_RST;
		else
			latch_q <= latch_d;
	end

	// ==========================================================
	// Read port
	// Writes are never decoded: both slots are read-only.
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	logic rhit_q;
	logic rhit_d;

	always_comb
	begin
		rdata_d = rdata_q;
		rvalid_d = rvalid_q;
		rhit_d = rhit_q;
		if (clk_en)
		begin
			rvalid_d = req.rd;
			rhit_d = 1'b0;
			if (req.rd)
			begin
				if (req.addr == SECL_OFS_EVENT_LATCH)
				begin
					rdata_d = latch_q;
					rhit_d = 1'b1;
				end
				else if (req.addr == SECL_OFS_RSVD_SLOT)
				begin
					rdata_d = SECL_RSVD_SLOT_VALUE;
					rhit_d = 1'b1;
				end
				else
					rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			rhit_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			rhit_q <= rhit_d;
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign rhit = rhit_q;

endmodule // secl_event_latch

// file: rtl/secl_pkg.sv
// Package for the event-change latch of the four-port video switch.
// Assumes one core clock; register reads arrive from a local slave port.
package secl_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] SECL_OFS_PORT_STATUS = 8'h01;
	localparam logic [7:0] SECL_OFS_RSVD_SLOT = 8'h06;
	localparam logic [7:0] SECL_OFS_EVENT_LATCH = 8'h07;

	// ==========================================================
	// Event latch field positions
	localparam int SECL_BIT_PORT_SEL = 5;
	localparam int SECL_BIT_CLK_DET = 4;
	localparam int SECL_BIT_SUPPLY_HI = 3;
	localparam int SECL_BIT_SUPPLY_LO = 0;
	localparam int SECL_NUM_PORTS = 4;

	// ==========================================================
	// Reset values
	localparam logic [7:0] SECL_EVENT_LATCH_RST = 8'h00;
	localparam logic [5:0] SECL_FLAGS_RST = 6'h00;
	// Arbitrary value returned by the reserved slot
	localparam logic [7:0] SECL_RSVD_SLOT_VALUE = 8'h00;

	// ==========================================================
	// Timing
	// Enabled edges before deltas count: two sync stages, one baseline
	localparam logic [1:0] SECL_PRIME_DONE = 2'h3;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [1:0] port_sel;
		logic clk_detect;
		logic [SECL_NUM_PORTS-1:0] port_supply_sense;
	} secl_status_type;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} secl_req_type;

endpackage

// file: verif/secl_event_latch_asserts.sv
// Port checker for the event latch.
// Bound from the bench top; sees ports only.
`timescale 1ns/1ps
module secl_chk
	import secl_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire secl_status_type status_in,
	input wire secl_req_type req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic rhit,
	input wire logic irq
);
	logic [7:0] a_q;
	logic [2:0] q_q;
	logic [1:0] r_q;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// ====
	// Quiet time lets the pin syncs drain
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			q_q <= 3'h0;
		else if (!$stable(status_in))
			q_q <= 3'h0;
		else if (clk_en && q_q != 3'h7)
			q_q <= q_q + 3'h1;
	end
	// Enabled edges since reset; changes only count once it is full
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			r_q <= 2'h0;
		else if (clk_en && r_q != 2'h3)
			r_q <= r_q + 2'h1;
	end
	always_ff @(posedge core_clk)
	begin
		if (clk_en && req.rd)
			a_q <= req.addr;
	end
	chk_rsvd_read: assert property (
		rvalid && a_q == 8'h06 |-> rhit && rdata == SECL_RSVD_SLOT_VALUE)
		else $error("reserved slot");
	chk_top_zero: assert property (
		rvalid |-> rdata[7:6] == 2'h0) else $error("top bits");
	chk_wr_quiet: assert property (
		clk_en && !req.rd |=> !rvalid) else $error("stray answer");
	chk_port_flag: assert property (
		clk_en && $past(clk_en) && r_q == 2'h3 &&
		$changed(status_in.port_sel) |=> irq)
		else $error("port change");
	chk_clk_flag: assert property (
		clk_en && $past(clk_en) && r_q == 2'h3 &&
		$changed(status_in.clk_detect) ##1 clk_en[*2] |=> irq)
		else $error("clock detect");
	chk_sup_flag: assert property (
		clk_en && $past(clk_en) && r_q == 2'h3 &&
		$changed(status_in.port_supply_sense) ##1 clk_en[*2]
		|=> irq) else $error("supply sense");
	chk_clear_irq: assert property (
		clk_en && req.rd && req.addr == SECL_OFS_PORT_STATUS &&
		$stable(status_in) && q_q > 3'h3 |=> !irq)
		else $error("clear");
	chk_latch_irq: assert property (
		rvalid && a_q == 8'h07 |-> rhit && (rdata != 8'h00) == $past(irq))
		else $error("latch");
endmodule // secl_chk

// file: verif/secl_host.sv
// Sink microcontroller model: single byte transfers.
// Answer is expected one cycle after a taken request.
`timescale 1ns/1ps
module secl_host
	import secl_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output secl_req_type req
);
	initial req = '0;
	// ====
	// Released address is inverted, never left stale
	task automatic xfer(input logic w, input logic [7:0] a,
		output logic [7:0] d);
		@(negedge core_clk);
		req = '{!w, w, a, 8'h5a};
		@(negedge core_clk);
		req = '{1'b0, 1'b0, ~a, 8'ha5};
		d = rvalid ? rdata : 8'hxx;
	endtask
endmodule // secl_host

// file: verif/tb_switch_event_change_latch.sv
// Bench: status change table, then hand cases.
// Needs the package, latch, host model and checker.
`timescale 1ns/1ps
module tb_switch_event_change_latch
	import secl_pkg::*;
;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic irq;
	secl_status_type st = '0;
	secl_req_type req;
	logic [7:0] rdata;
	logic [7:0] d;
	logic rvalid;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Status to drive, then the latch it gives
	logic [14:0] rows[7] = '{15'h2020, 15'h3010, 15'h3101, 15'h3302,
		15'h3704, 15'h3f08, 15'h003f};
	always #50 core_clk = ~core_clk;
	secl_event_latch dut_u (.core_clk(core_clk), .resetn(resetn),
		.clk_en(clk_en), .status_in(st), .req(req), .rdata(rdata),
		.rvalid(rvalid), .rhit(), .irq(irq));
	secl_host host_u (.core_clk(core_clk), .rdata(rdata),
		.rvalid(rvalid), .req(req));
	// ====
	// Checks and closing
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host_u.xfer(1'b0, a, d);
		chk("rdata", d, e);
	endtask
	task stop_test;
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			fails++;
			stop_test;
		end
	end
	initial
	begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		// Changes only count once the pin syncs are primed
		repeat (4) @(negedge core_clk);
		foreach (rows[i])
		begin
			st = rows[i][14:8];
			repeat (5) @(negedge core_clk);
			rd(8'h07, rows[i][7:0]);
			chk("irq", {7'h00, irq}, 8'h01);
			rd(8'h01, 8'h00);
			chk("irq", {7'h00, irq}, 8'h00);
			rd(8'h07, 8'h00);
			$display("Row %0d done", i);
		end
		// A low clock enable hides the change until it returns
		clk_en = 1'b0;
		st = 7'h40;
		repeat (5) @(negedge core_clk);
		chk("irq", {7'h00, irq}, 8'h00);
		clk_en = 1'b1;
		// Events pile up while nobody reads the status
		repeat (5) @(negedge core_clk);
		st = 7'h41;
		repeat (5) @(negedge core_clk);
		host_u.xfer(1'b1, 8'h07, d);
		rd(8'h07, 8'h21);
		chk("irq", {7'h00, irq}, 8'h01);
		rd(8'h06, SECL_RSVD_SLOT_VALUE);
		st = 7'h00;
		repeat (5) @(negedge core_clk);
		resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		rd(8'h07, 8'h00);
		chk("irq", {7'h00, irq}, 8'h00);
		$display("Hand cases done");
		stop_test;
	end
endmodule // tb_switch_event_change_latch
bind secl_event_latch secl_chk chk_u (.core_clk(core_clk),
	.resetn(resetn), .clk_en(clk_en), .status_in(status_in),
	.req(req), .rdata(rdata), .rvalid(rvalid), .rhit(rhit), .irq(irq));
